/* rtl/nvt_pkg.sv */
package nvt_pkg;

  // ************************************************************
  // Array and port geometry
  // ************************************************************
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH  = 32768;

  // Clock registers sit in the top eight locations
  localparam logic [11:0] CLK_PAGE = 12'hFFF;
  localparam logic [2:0]  IDX_CEN  = 3'h0;
  localparam logic [2:0]  IDX_SEC  = 3'h1;
  localparam logic [2:0]  IDX_MIN  = 3'h2;
  localparam logic [2:0]  IDX_HOUR = 3'h3;
  localparam logic [2:0]  IDX_DAY  = 3'h4;
  localparam logic [2:0]  IDX_DATE = 3'h5;
  localparam logic [2:0]  IDX_MON  = 3'h6;
  localparam logic [2:0]  IDX_YEAR = 3'h7;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned WRITE_HALT_BIT  = 7;
  localparam int unsigned READ_HALT_BIT   = 6;
  localparam int unsigned OSC_STOP_BIT    = 7;
  localparam int unsigned BATT_GOOD_BIT   = 7;
  localparam int unsigned FREQ_TEST_BIT   = 6;
  localparam int unsigned TEST_OUT_BIT    = 0;

  // Counter-owned bits of each clock byte, index order
  localparam logic [7:0] VAL_MASK [8] = '{8'h3F, 8'h7F, 8'h7F, 8'h3F,
                                          8'h07, 8'h3F, 8'h1F, 8'hFF};

  // ************************************************************
  // Reset values and calendar limits (BCD)
  // ************************************************************
  localparam logic [7:0] VIS_RESET  = 8'h00;
  localparam logic [7:0] ONE_BCD    = 8'h01;
  localparam logic [7:0] ZERO_BCD   = 8'h00;
  localparam logic [7:0] MAX_SEC    = 8'h59;
  localparam logic [7:0] MAX_HOUR   = 8'h23;
  localparam logic [7:0] MAX_DAY    = 8'h07;
  localparam logic [7:0] MAX_MON    = 8'h12;
  localparam logic [7:0] MAX_YEAR   = 8'h99;
  localparam logic [7:0] MAX_CEN    = 8'h39;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned TEST_HZ          = 512;
  localparam int unsigned HALF_TICK_CYCLES = CLK_HZ / (2 * TEST_HZ);
  localparam int unsigned SUB_PER_SEC      = 2 * TEST_HZ;
  localparam int unsigned SUB_W            = $clog2(SUB_PER_SEC);

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } nvt_time_t;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nvt_pins_t;

endpackage

/* rtl/nvt_calendar.sv */
module nvt_calendar (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  input  wire logic              sec_tick,
  input  wire logic              load,
  input  wire nvt_pkg::nvt_time_t load_val,
  output nvt_pkg::nvt_time_t     cur
);

  // ************************************************************
  // BCD step with wrap flag
  // ************************************************************
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v >= hi) begin
      return {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction

  nvt_pkg::nvt_time_t next_cur;
  logic [7:0]         month_end;
  logic               leap;
  logic [8:0]         s_st, m_st, h_st, d_st, dt_st, mo_st, y_st, c_st;

  // Leap year when BCD year is a multiple of four
  always_comb begin
    leap = cur.year[4] ? (cur.year[3:0] == 4'h2 || cur.year[3:0] == 4'h6)
                       : (cur.year[3:0] == 4'h0 || cur.year[3:0] == 4'h4
                          || cur.year[3:0] == 4'h8);
  end

  always_comb begin
    unique case (cur.month)
      8'h02:                      month_end = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default:                    month_end = 8'h31;
    endcase
  end

  always_comb begin
    s_st  = bcd_step(cur.second, nvt_pkg::ZERO_BCD, nvt_pkg::MAX_SEC);
    m_st  = bcd_step(cur.minute, nvt_pkg::ZERO_BCD, nvt_pkg::MAX_SEC);
    h_st  = bcd_step(cur.hour,   nvt_pkg::ZERO_BCD, nvt_pkg::MAX_HOUR);
    d_st  = bcd_step(cur.day,    nvt_pkg::ONE_BCD,  nvt_pkg::MAX_DAY);
    dt_st = bcd_step(cur.date,   nvt_pkg::ONE_BCD,  month_end);
    mo_st = bcd_step(cur.month,  nvt_pkg::ONE_BCD,  nvt_pkg::MAX_MON);
    y_st  = bcd_step(cur.year,   nvt_pkg::ZERO_BCD, nvt_pkg::MAX_YEAR);
    c_st  = bcd_step(cur.century, nvt_pkg::ZERO_BCD, nvt_pkg::MAX_CEN);
    next_cur        = cur;
    next_cur.second = s_st[7:0];
    if (s_st[8]) begin
      next_cur.minute = m_st[7:0];
    end
    if (s_st[8] && m_st[8]) begin
      next_cur.hour = h_st[7:0];
    end
    if (s_st[8] && m_st[8] && h_st[8]) begin
      next_cur.day  = d_st[7:0];
      next_cur.date = dt_st[7:0];
    end
    if (s_st[8] && m_st[8] && h_st[8] && dt_st[8]) begin
      next_cur.month = mo_st[7:0];
    end
    if (s_st[8] && m_st[8] && h_st[8] && dt_st[8] && mo_st[8]) begin
      next_cur.year = y_st[7:0];
    end
    if (s_st[8] && m_st[8] && h_st[8] && dt_st[8] && mo_st[8] && y_st[8]) begin
      next_cur.century = c_st[7:0];
    end
  end

  // Internal counters, load has priority over the tick
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur <= '{century: 8'h00, year: 8'h00, month: 8'h01, date: 8'h01,
               day: 8'h01, hour: 8'h00, minute: 8'h00, second: 8'h00};
    end else if (clk_en) begin
      if (load) begin
        cur <= load_val;
      end else if (sec_tick) begin
        cur <= next_cur;
      end
    end
  end

endmodule

/* rtl/nvt_top.sv */
module nvt_top #(
  parameter int unsigned HALF_TICK_CYCLES = nvt_pkg::HALF_TICK_CYCLES
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        clk_en,
  input  wire logic [nvt_pkg::ADDR_W-1:0]  address_lines,
  input  wire logic                        chip_sel_n,
  input  wire logic                        out_en_n,
  input  wire logic                        write_n,
  input  wire logic [nvt_pkg::DATA_W-1:0]  data_lines_in,
  input  wire logic                        power_fail,
  input  wire logic                        battery_good,
  output logic      [nvt_pkg::DATA_W-1:0]  data_lines_out,
  output logic                             data_lines_oe
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  nvt_pkg::nvt_pins_t raw_pins, meta_pins, pins;
  logic               pf_meta, pf_s, bg_meta, bg_s;

  assign raw_pins = '{ce_n: chip_sel_n, oe_n: out_en_n, we_n: write_n,
                      addr: address_lines, data: data_lines_in};

  // Two stages for every pin input
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_pins <= '1;
      pins      <= '1;
      pf_meta   <= 1'b1;
      pf_s      <= 1'b1;
      bg_meta   <= 1'b1;
      bg_s      <= 1'b1;
    end else if (clk_en) begin
      meta_pins <= raw_pins;
      pins      <= meta_pins;
      pf_meta   <= power_fail;
      pf_s      <= pf_meta;
      bg_meta   <= battery_good;
      bg_s      <= bg_meta;
    end
  end

  // ************************************************************
  // Port decode
  // ************************************************************
  logic       acc_ok, wr_en, rd_en, is_clk, clk_wr;
  logic [2:0] idx;

  assign acc_ok = !pf_s && !pins.ce_n;
  assign wr_en  = acc_ok && !pins.we_n;
  assign rd_en  = acc_ok && !pins.oe_n && pins.we_n;
  assign is_clk = (pins.addr[nvt_pkg::ADDR_W-1:3] == nvt_pkg::CLK_PAGE);
  assign idx    = pins.addr[2:0];
  assign clk_wr = wr_en && is_clk;

  // ************************************************************
  // Storage array
  // ************************************************************
  logic [nvt_pkg::DATA_W-1:0] mem [nvt_pkg::DEPTH];

  // plain byte writes below the clock page
  always_ff @(posedge core_clk) begin
    if (clk_en && wr_en && !is_clk) begin
      mem[pins.addr] <= pins.data;
    end
  end

  // ************************************************************
  // Oscillator divider
  // ************************************************************
  logic [$clog2(HALF_TICK_CYCLES)-1:0] div_cnt;
  logic [nvt_pkg::SUB_W-1:0]           sub_cnt;
  logic                                half_tick, sec_tick, test_toggle, osc_run;
  logic                                load;
  logic [7:0]                          vis [8];

  assign osc_run   = !vis[nvt_pkg::IDX_SEC][nvt_pkg::OSC_STOP_BIT];
  assign half_tick = osc_run
                     && (div_cnt == ($clog2(HALF_TICK_CYCLES))'(HALF_TICK_CYCLES - 1));
  assign sec_tick  = half_tick
                     && (sub_cnt == nvt_pkg::SUB_W'(nvt_pkg::SUB_PER_SEC - 1));

  // Divider and 512Hz toggle, divider restarted on a time load, toggle kept
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_cnt     <= '0;
      sub_cnt     <= '0;
      test_toggle <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        div_cnt <= '0;
        sub_cnt <= '0;
      end else if (half_tick) begin
        div_cnt     <= '0;
        sub_cnt     <= sub_cnt + 1'b1;
        test_toggle <= !test_toggle;
      end else if (osc_run) begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // ************************************************************
  // Internal counters
  // ************************************************************
  nvt_pkg::nvt_time_t cur, load_val;
  logic [7:0]         cur_b [8];

  assign load_val = '{century: vis[0] & nvt_pkg::VAL_MASK[0],
                      second:  vis[1] & nvt_pkg::VAL_MASK[1],
                      minute:  vis[2] & nvt_pkg::VAL_MASK[2],
                      hour:    vis[3] & nvt_pkg::VAL_MASK[3],
                      day:     vis[4] & nvt_pkg::VAL_MASK[4],
                      date:    vis[5] & nvt_pkg::VAL_MASK[5],
                      month:   vis[6] & nvt_pkg::VAL_MASK[6],
                      year:    vis[7] & nvt_pkg::VAL_MASK[7]};

  assign cur_b = '{cur.century, cur.second, cur.minute, cur.hour,
                   cur.day, cur.date, cur.month, cur.year};

  nvt_calendar u_cal (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .sec_tick (sec_tick),
    .load     (load),
    .load_val (load_val),
    .cur      (cur)
  );

  // ************************************************************
  // Visible registers
  // ************************************************************
  logic halt, w_prev;

  assign halt = vis[nvt_pkg::IDX_CEN][nvt_pkg::READ_HALT_BIT]
                || vis[nvt_pkg::IDX_CEN][nvt_pkg::WRITE_HALT_BIT];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      w_prev <= 1'b0;
    end else if (clk_en) begin
      w_prev <= vis[nvt_pkg::IDX_CEN][nvt_pkg::WRITE_HALT_BIT];
    end
  end
  assign load = w_prev && !vis[nvt_pkg::IDX_CEN][nvt_pkg::WRITE_HALT_BIT];

  // Host writes win, else counters copied while not halted and not loading
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        vis[i] <= nvt_pkg::VIS_RESET;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        if (clk_wr && idx == 3'(i)) begin
          // control and spare bits stored as written
          vis[i] <= pins.data;
        end else if (!halt && !load) begin
          // every byte not being written refreshed together, spare bits kept
          vis[i] <= (vis[i] & ~nvt_pkg::VAL_MASK[i]) | (cur_b[i] & nvt_pkg::VAL_MASK[i]);
        end
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] clk_rd;
  logic       ft_on;

  assign ft_on = vis[nvt_pkg::IDX_DAY][nvt_pkg::FREQ_TEST_BIT] && osc_run;

  // Clock byte read value with live overlays
  always_comb begin
    clk_rd = vis[idx];
    // battery flag from pin, not storage
    if (idx == nvt_pkg::IDX_DAY) begin
      clk_rd[nvt_pkg::BATT_GOOD_BIT] = bg_s;
    end
    // live test toggle on line 0
    if (idx == nvt_pkg::IDX_SEC && ft_on) begin
      clk_rd[nvt_pkg::TEST_OUT_BIT] = test_toggle;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_lines_out <= '0;
      data_lines_oe  <= 1'b0;
    end else if (clk_en) begin
      data_lines_out <= is_clk ? clk_rd : mem[pins.addr];
      data_lines_oe  <= rd_en;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_pf_release: assert property (clk_en && pf_s |=> !data_lines_oe)
    else $error("data lines driven during power fail");
  chk_read_drive: assert property (clk_en && rd_en |=> data_lines_oe)
    else $error("read cycle did not drive data lines");
  chk_write_quiet: assert property (clk_en && (wr_en || pins.ce_n) |=> !data_lines_oe)
    else $error("data lines driven during write or deselect");
  chk_read_hold: assert property (clk_en && halt && !clk_wr
                                  |=> $stable(vis[nvt_pkg::IDX_SEC]))
    else $error("visible seconds changed while halted");
  chk_refresh_copy: assert property (clk_en && !halt && !load && !clk_wr
      |=> (vis[nvt_pkg::IDX_MIN] & nvt_pkg::VAL_MASK[2]) == $past(cur.minute))
    else $error("visible minutes not refreshed from counters");
  chk_write_load: assert property (clk_en && load
      |=> cur.hour == $past(vis[nvt_pkg::IDX_HOUR] & nvt_pkg::VAL_MASK[3]))
    else $error("counters not loaded on write halt release");
  chk_osc_freeze: assert property (clk_en && !osc_run && !load |=> $stable(cur))
    else $error("time advanced with oscillator stopped");
  chk_batt_flag: assert property (clk_en && rd_en && is_clk && idx == nvt_pkg::IDX_DAY
      |=> data_lines_out[7] == $past(bg_s))
    else $error("battery flag not shown on day read");
  chk_test_live: assert property (clk_en && rd_en && is_clk && idx == nvt_pkg::IDX_SEC
      && ft_on |=> data_lines_out[0] == $past(test_toggle))
    else $error("test toggle missing on seconds read");

  cov_time_load: cover property (clk_en && load);
  cov_sec_roll: cover property (clk_en && sec_tick && cur.second == nvt_pkg::MAX_SEC);
  cov_clock_read: cover property (clk_en && rd_en && is_clk);
  cov_pf_strobe: cover property (clk_en && pf_s && !pins.ce_n);

endmodule

/* tb/nvt_host_model.sv */
module nvt_host_model (
  input  wire logic          core_clk,
  input  wire logic [7:0]    data_lines_out,
  input  wire logic          data_lines_oe,
  output nvt_pkg::nvt_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Idle bus
  // ************************************************************

  // Strobes inactive from time zero
  initial begin
    pins = '0;
    pins.ce_n = 1'b1;
    pins.oe_n = 1'b1;
    pins.we_n = 1'b1;
  end

  // ************************************************************
  // Bus cycles
  // ************************************************************

  task automatic drive(input logic [2:0] cow, input logic [14:0] a, input logic [7:0] d,
                       input int n);
    @(negedge core_clk);
    pins.addr = a;
    pins.data = d;
    @(negedge core_clk);
    {pins.ce_n, pins.oe_n, pins.we_n} = cow;
    repeat (n) @(negedge core_clk);
    {pins.ce_n, pins.oe_n, pins.we_n} = 3'b111;
    repeat (3) @(negedge core_clk);
    pins.data = ~d; // Released lines show the inverse
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    drive(3'b010, a, d, 4);
  endtask

  // read cycle, held extra cycles on request
  task automatic rd(input logic [14:0] a, input int hold, output logic [7:0] q);
    int k;
    @(negedge core_clk);
    pins.addr = a;
    @(negedge core_clk);
    {pins.ce_n, pins.oe_n, pins.we_n} = 3'b001;
    k = 0;
    while (data_lines_oe !== 1'b1 && k < 10) begin
      @(negedge core_clk);
      k++;
    end
    q = (k < 10) ? data_lines_out : 8'hXX; // No answer never matches
    repeat (hold) @(negedge core_clk);
    {pins.ce_n, pins.oe_n, pins.we_n} = 3'b111;
    repeat (3) @(negedge core_clk);
  endtask
endmodule

/* tb/nv_sram_timekeeper_tb.sv */
module nv_sram_timekeeper_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Setup
  // ************************************************************
  localparam int HT = 4;
  localparam int SEC = 1024 * HT; // Cycles per second
  localparam int T500 = 12500;    // 500us at 25 MHz
  localparam logic [14:0] A_CEN = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_CEN};
  localparam logic [14:0] A_SEC = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_SEC};
  localparam logic [14:0] A_MIN = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_MIN};
  localparam logic [14:0] A_HR  = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_HOUR};
  localparam logic [14:0] A_DAY = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_DAY};
  localparam logic [14:0] A_DT  = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_DATE};
  localparam logic [14:0] A_MON = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_MON};
  localparam logic [14:0] A_YR  = {nvt_pkg::CLK_PAGE, nvt_pkg::IDX_YEAR};

  logic               core_clk;
  logic               reset;
  logic               power_fail;
  logic               battery_good;
  logic               oe_seen;
  logic [7:0]         dout;
  logic               dout_oe;
  logic [7:0]         q;
  logic [2:0]         pat [3];
  nvt_pkg::nvt_pins_t pins;
  int                 num_errors;
  int                 cmp_count;

  // Device and host
  nvt_top #(.HALF_TICK_CYCLES(HT)) u_dut (
    .core_clk(core_clk), .reset(reset), .clk_en(1'b1), .address_lines(pins.addr),
    .chip_sel_n(pins.ce_n), .out_en_n(pins.oe_n), .write_n(pins.we_n),
    .data_lines_in(pins.data), .power_fail(power_fail), .battery_good(battery_good),
    .data_lines_out(dout), .data_lines_oe(dout_oe)
  );
  nvt_host_model u_host (
    .core_clk(core_clk), .data_lines_out(dout), .data_lines_oe(dout_oe), .pins(pins)
  );

  // Clock
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // Remember any drive of the data lines
  always @(negedge core_clk) if (dout_oe === 1'b1) oe_seen = 1'b1;

  // ************************************************************
  // Helpers
  // ************************************************************

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read and compare
  task automatic rc(input logic [14:0] a, input logic [7:0] exp);
    u_host.rd(a, 0, q);
    check(q, exp);
  endtask

  // Count rising edges of line 0 during a held seconds read
  task automatic tog_chk(input logic [7:0] exp);
    logic       prev;
    logic [7:0] n;
    n = 8'h00;
    fork
      u_host.rd(A_SEC, 40, q);
      begin
        wait (dout_oe === 1'b1);
        @(negedge core_clk);
        prev = dout[0];
        repeat (32) begin
          @(negedge core_clk);
          if (dout[0] && !prev) n++;
          prev = dout[0];
        end
      end
    join
    check(n, exp);
  endtask

  // Load time bytes under write halt
  task automatic set_byte(input logic [14:0] a, input logic [7:0] d);
    u_host.wr(A_CEN, 8'hA0);
    u_host.wr(a, d);
    u_host.wr(A_CEN, 8'h20);
  endtask

  // Verdict
  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #3_000_000;
    num_errors++;
    end_of_test();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    reset = 1'b1;
    power_fail = 1'b0;
    battery_good = 1'b1;
    oe_seen = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    pat = '{3'b101, 3'b011, 3'b100};
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    check({7'h00, dout_oe}, 8'h00);
    rc(A_MON, 8'h01);
    u_host.wr(15'h0000, 8'h5A);
    u_host.wr(15'h7FF7, 8'hC3);
    u_host.wr(15'h0123, 8'hA5);
    rc(15'h0000, 8'h5A);
    rc(15'h7FF7, 8'hC3);
    // Load 23:59:59 on a leap-year 28th
    u_host.wr(A_CEN, 8'hA0);
    u_host.wr(A_YR, 8'h24);
    u_host.wr(A_MON, 8'hC2);
    u_host.wr(A_DT, 8'h28);
    u_host.wr(A_DAY, 8'h03);
    u_host.wr(A_HR, 8'h23);
    u_host.wr(A_MIN, 8'h59);
    u_host.wr(A_SEC, 8'h59);
    u_host.wr(A_CEN, 8'h20);
    repeat (SEC / 2) @(negedge core_clk);
    rc(A_SEC, 8'h59);
    repeat (SEC) @(negedge core_clk);
    u_host.wr(A_CEN, 8'h60);
    rc(A_SEC, 8'h00);
    rc(A_MIN, 8'h00);
    rc(A_HR, 8'h00);
    rc(A_DT, 8'h29);
    rc(A_MON, 8'hC2);
    rc(A_DAY, 8'h84);
    rc(A_YR, 8'h24);
    rc(A_CEN, 8'h60);
    repeat (SEC) @(negedge core_clk);
    rc(A_SEC, 8'h00);
    u_host.wr(A_CEN, 8'h20);
    repeat (T500) @(negedge core_clk);
    rc(A_SEC, 8'h04);
    set_byte(A_SEC, 8'h80);
    repeat (2 * SEC) @(negedge core_clk);
    rc(A_SEC, 8'h80);
    set_byte(A_SEC, 8'h10);
    repeat (SEC / 2) @(negedge core_clk);
    rc(A_SEC, 8'h10);
    repeat (SEC) @(negedge core_clk);
    rc(A_SEC, 8'h11);
    set_byte(A_DAY, 8'h44);
    rc(A_DAY, 8'hC4);
    tog_chk(8'h04);
    battery_good = 1'b0;
    set_byte(A_DAY, 8'h84);
    repeat (3) @(negedge core_clk);
    rc(A_DAY, 8'h04);
    tog_chk(8'h00);
    // Power fail blocks access
    power_fail = 1'b1;
    repeat (3) @(negedge core_clk);
    oe_seen = 1'b0;
    u_host.wr(15'h0123, 8'h00);
    u_host.rd(15'h0123, 0, q);
    check({7'h00, oe_seen}, 8'h00);
    power_fail = 1'b0;
    repeat (3) @(negedge core_clk);
    rc(15'h0123, 8'hA5);
    // Strobe patterns that neither read nor write
    for (int i = 0; i < 3; i++) begin
      oe_seen = 1'b0;
      u_host.drive(pat[i], 15'h0123, 8'h00, 6);
      check({7'h00, oe_seen}, 8'h00);
      rc(15'h0123, 8'hA5);
    end
    end_of_test();
  end
endmodule
